// >>> rtl/crcd_regs.vh
// Offsets, field positions, reset values and timing counts of the bridge control registers
// Notes on behaviour
// - Retry-expired flag sets when a retried master misses 2^15 clocks.
// - Expired flags stay set until software writes one; zero leaves them.
// - Retry status bit 7 enables host retry counter; resets to one.
// - Retry status bit 6 enables card retry counters; resets to one.
// - Bit 5 reads one after card path B retry expires; resets zero.
// - Bit 3 reads one after card path A retry expires; resets zero.
// - Bit 1 reads one after host target retry expires; resets zero.
// - Retry status bits 4, 2, 0 ignore writes and read zero.
// - Ring enable zero blocks ring output; one routes it to MFUNC, and to the wake terminal only while ring terminal select is zero.
// - Video enable bit tri-states socket video terminals; resets zero.
// - Audio-to-mux bit forwards card audio to the audio PWM terminal.
// - Speaker terminal driven with card speaker only while enable is one.
// - Card control bit 0 sets on card interrupt, clears on write one.
// - Power lock set ignores socket power-off requests while in D3.
// - Device control bit 6 forces 3-V capability report; resets one.
// - Bits 2:1 select interrupt signaling mode; reset value 11.
// - Device control bit 5 is writable diagnostic, resets one.
// - Card control bits 4 and 3 read zero.
// - Device control bit 4 reads zero.
`ifndef CRCD_REGS_VH
`define CRCD_REGS_VH

// Register indices; byte address is four times the index
`define CRCD_IDX_RETRY 12'h0090
`define CRCD_IDX_CARD 12'h0091
`define CRCD_IDX_DEV 12'h0092

// Reset values
`define CRCD_RST_RETRY 8'hc0
`define CRCD_RST_CARD 8'h00
`define CRCD_RST_DEV 8'h66

// Retry status fields
`define CRCD_RS_HOST_EN 7
`define CRCD_RS_CARD_EN 6
`define CRCD_RS_B_EXP 5
`define CRCD_RS_A_EXP 3
`define CRCD_RS_H_EXP 1

// Card control fields
`define CRCD_CC_RING_EN 7
`define CRCD_CC_VIDEO 6
`define CRCD_CC_RSVD5 5
`define CRCD_CC_AUDIO 2
`define CRCD_CC_CARD_SPEAKER_SIGNAL 1
`define CRCD_CC_IRQ 0

// Device control fields
`define CRCD_DC_LOCK 7
`define CRCD_DC_LV_CAP 6
`define CRCD_DC_DIAG 5
`define CRCD_DC_TEST3 3
`define CRCD_DC_MODE_HI 2
`define CRCD_DC_MODE_LO 1
`define CRCD_DC_TEST0 0

// Retry timeout, in bus clock cycles
`define CRCD_RETRY_LIMIT_CYC 16'h8000

// AHB transfer type
`define CRCD_HTRANS_NONSEQ 2'b10

`endif

// >>> rtl/crcd_retry_timer.v
// One retry timeout counter for a single master path
`timescale 1ns/1ps
`default_nettype none
module crcd_retry_timer #(
  parameter [15:0] LIMIT = 16'h8000
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire enable_in,
  input wire retry_in,
  input wire return_in,
  output reg expired_out
);
  reg run_ff;
  reg [15:0] count_ff;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_ff <= 1'b0;
      count_ff <= 16'h0000;
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b0;
      if (!enable_in || return_in) begin
        // Disabled or master came back: stop and clear
        run_ff <= 1'b0;
        count_ff <= 16'h0000;
      end else if (run_ff) begin
        if (count_ff == LIMIT - 16'h0001) begin
          expired_out <= 1'b1;
          run_ff <= 1'b0;
          count_ff <= 16'h0000;
        end else begin
          count_ff <= count_ff + 16'h0001;
        end
      end else if (retry_in) begin
        // First retry starts the count; later retries do not restart it
        run_ff <= 1'b1;
        count_ff <= 16'h0000;
      end
    end
  end
endmodule // crcd_retry_timer
`default_nettype wire

// >>> rtl/crcd_top.v
// Retry, card control and device control registers behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "crcd_regs.vh"
module crcd_top #(
  parameter [15:0] RETRY_LIMIT = `CRCD_RETRY_LIMIT_CYC
) (
  input wire clk_in,
  input wire rst_n_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Retry paths: bit 0 host, bit 1 card A, bit 2 card B
  input wire [2:0] retry_issued_in,
  input wire [2:0] master_returned_in,
  // Card side signals
  input wire ring_indicate_output_in,
  input wire ring_terminal_select_in,
  input wire card_audio_signal_in,
  input wire card_speaker_signal_in,
  input wire card_functional_irq_in,
  // Power management
  input wire in_d3_state_in,
  input wire socket_power_off_req_in,
  // Routed outputs
  output reg ring_to_mfunc_out,
  output reg ring_to_wake_terminal_out,
  output reg compat_video_hiz_out,
  output reg card_audio_pwm_function_out,
  output reg speaker_output_terminal_out,
  output reg speaker_output_oe_out,
  output reg socket_power_off_out,
  output reg low_voltage_capable_out,
  output reg [1:0] irq_signaling_mode_out
);

  // Register select codes
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_RETRY = 2'b01;
  localparam [1:0] SEL_CARD = 2'b10;
  localparam [1:0] SEL_DEV = 2'b11;

  // Bus phase states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WRITE = 2'b01;
  localparam [1:0] ST_READ = 2'b10;
  localparam [1:0] ST_RDONE = 2'b11;

  // Reset images, so single bits can be picked at their field positions
  localparam [7:0] RST_RETRY = `CRCD_RST_RETRY;
  localparam [7:0] RST_CARD = `CRCD_RST_CARD;
  localparam [7:0] RST_DEV = `CRCD_RST_DEV;

  // Word address decode shared by read and write
  function [1:0] crcd_reg_sel;
    input [31:0] addr;
    begin
      if (addr == {18'h0_0000, `CRCD_IDX_RETRY, 2'b00}) begin
        crcd_reg_sel = SEL_RETRY;
      end else if (addr == {18'h0_0000, `CRCD_IDX_CARD, 2'b00}) begin
        crcd_reg_sel = SEL_CARD;
      end else if (addr == {18'h0_0000, `CRCD_IDX_DEV, 2'b00}) begin
        crcd_reg_sel = SEL_DEV;
      end else begin
        crcd_reg_sel = SEL_NONE;
      end
    end
  endfunction

  // Write strobe of one register, taken at the end of the data phase
  function crcd_wr_hit;
    input take;
    input [1:0] sel;
    input [1:0] want;
    begin
      crcd_wr_hit = take && (sel == want);
    end
  endfunction

  reg [1:0] state_ff;
  reg [1:0] sel_ff;

  // Register state
  reg host_retry_counter_en_ff;
  reg card_retry_counter_en_ff;
  reg host_retry_expired_ff;
  reg card_a_retry_expired_ff;
  reg card_b_retry_expired_ff;
  reg ring_output_enable_ff;
  reg compat_video_enable_ff;
  reg card_rsvd5_ff;
  reg audio_to_mux_enable_ff;
  reg speaker_route_enable_ff;
  reg card_functional_irq_flag_ff;
  reg socket_power_lock_ff;
  reg low_voltage_capable_force_ff;
  reg diagnostic_default_one_ff;
  reg test_bit3_ff;
  reg [1:0] irq_signaling_mode_ff;
  reg test_bit0_ff;

  wire [2:0] timer_en;
  wire [2:0] expired;
  wire addr_ok;
  wire wr_take;
  wire rd_req;
  wire wr_req;
  wire wr_retry;
  wire wr_card;
  wire wr_dev;
  wire [2:0] flag_clr;
  wire [7:0] wdat;
  wire [7:0] retry_view;
  wire [7:0] card_view;
  wire [7:0] dev_view;
  reg [7:0] rd_mux;

  // Host counter gated by bit 7, both card paths by bit 6
  assign timer_en = {card_retry_counter_en_ff, card_retry_counter_en_ff,
                     host_retry_counter_en_ff};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_timer
      crcd_retry_timer #(
        .LIMIT(RETRY_LIMIT)
      ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(timer_en[gi]),
        .retry_in(retry_issued_in[gi]),
        .return_in(master_returned_in[gi]),
        .expired_out(expired[gi])
      );
    end
  endgenerate

  assign addr_ok = hsel_in && hready_in && (htrans_in == `CRCD_HTRANS_NONSEQ);
  assign wr_req = addr_ok && hwrite_in;
  assign rd_req = addr_ok && !hwrite_in;
  assign wr_take = (state_ff == ST_WRITE) && hready_in;
  assign wdat = hwdata_in[7:0];

  // One write strobe per register
  assign wr_retry = crcd_wr_hit(wr_take, sel_ff, SEL_RETRY);
  assign wr_card = crcd_wr_hit(wr_take, sel_ff, SEL_CARD);
  assign wr_dev = crcd_wr_hit(wr_take, sel_ff, SEL_DEV);

  // Write-one clears of the sticky expiry flags
  assign flag_clr[0] = wr_retry && wdat[`CRCD_RS_H_EXP];
  assign flag_clr[1] = wr_retry && wdat[`CRCD_RS_A_EXP];
  assign flag_clr[2] = wr_retry && wdat[`CRCD_RS_B_EXP];

  // Bus sequencing; reads take one wait state so write data is already stored
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      sel_ff <= SEL_NONE;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h0000_0000;
    end else begin
      hresp_out <= 1'b0;
      case (state_ff)
        ST_READ: begin
          hrdata_out <= {24'h00_0000, rd_mux};
          hreadyout_out <= 1'b1;
          state_ff <= ST_RDONE;
        end
        default: begin
          if (state_ff == ST_WRITE && !hready_in) begin
            state_ff <= ST_WRITE;
          end else if (wr_req) begin
            sel_ff <= crcd_reg_sel(haddr_in);
            state_ff <= ST_WRITE;
          end else if (rd_req) begin
            sel_ff <= crcd_reg_sel(haddr_in);
            hreadyout_out <= 1'b0;
            state_ff <= ST_READ;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Read views; reserved bits are wired to zero, except card control bit 5, which reads back as stored
  assign retry_view = {host_retry_counter_en_ff, card_retry_counter_en_ff,
                       card_b_retry_expired_ff, 1'b0,
                       card_a_retry_expired_ff, 1'b0,
                       host_retry_expired_ff, 1'b0};
  assign card_view = {ring_output_enable_ff, compat_video_enable_ff,
                      card_rsvd5_ff, 2'b00,
                      audio_to_mux_enable_ff, speaker_route_enable_ff,
                      card_functional_irq_flag_ff};
  assign dev_view = {socket_power_lock_ff, low_voltage_capable_force_ff,
                     diagnostic_default_one_ff, 1'b0,
                     test_bit3_ff, irq_signaling_mode_ff, test_bit0_ff};

  // Unmapped words read as zero
  always @* begin
    case (sel_ff)
      SEL_RETRY: begin
        rd_mux = retry_view;
      end
      SEL_CARD: begin
        rd_mux = card_view;
      end
      SEL_DEV: begin
        rd_mux = dev_view;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Retry status register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      host_retry_counter_en_ff <= RST_RETRY[`CRCD_RS_HOST_EN];
      card_retry_counter_en_ff <= RST_RETRY[`CRCD_RS_CARD_EN];
      host_retry_expired_ff <= RST_RETRY[`CRCD_RS_H_EXP];
      card_a_retry_expired_ff <= RST_RETRY[`CRCD_RS_A_EXP];
      card_b_retry_expired_ff <= RST_RETRY[`CRCD_RS_B_EXP];
    end else begin
      if (wr_retry) begin
        host_retry_counter_en_ff <= wdat[`CRCD_RS_HOST_EN];
        card_retry_counter_en_ff <= wdat[`CRCD_RS_CARD_EN];
      end
      // Set wins over a same-cycle write-one clear
      if (expired[0]) begin
        host_retry_expired_ff <= 1'b1;
      end else if (flag_clr[0]) begin
        host_retry_expired_ff <= 1'b0;
      end
      if (expired[1]) begin
        card_a_retry_expired_ff <= 1'b1;
      end else if (flag_clr[1]) begin
        card_a_retry_expired_ff <= 1'b0;
      end
      if (expired[2]) begin
        card_b_retry_expired_ff <= 1'b1;
      end else if (flag_clr[2]) begin
        card_b_retry_expired_ff <= 1'b0;
      end
    end
  end

  // Card control register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ring_output_enable_ff <= RST_CARD[`CRCD_CC_RING_EN];
      compat_video_enable_ff <= RST_CARD[`CRCD_CC_VIDEO];
      card_rsvd5_ff <= RST_CARD[`CRCD_CC_RSVD5];
      audio_to_mux_enable_ff <= RST_CARD[`CRCD_CC_AUDIO];
      speaker_route_enable_ff <= RST_CARD[`CRCD_CC_CARD_SPEAKER_SIGNAL];
      card_functional_irq_flag_ff <= RST_CARD[`CRCD_CC_IRQ];
    end else begin
      if (wr_card) begin
        ring_output_enable_ff <= wdat[`CRCD_CC_RING_EN];
        compat_video_enable_ff <= wdat[`CRCD_CC_VIDEO];
        // Stored as written; software keeps it at zero
        card_rsvd5_ff <= wdat[`CRCD_CC_RSVD5];
        audio_to_mux_enable_ff <= wdat[`CRCD_CC_AUDIO];
        speaker_route_enable_ff <= wdat[`CRCD_CC_CARD_SPEAKER_SIGNAL];
      end
      if (card_functional_irq_in) begin
        card_functional_irq_flag_ff <= 1'b1;
      end else if (wr_card && wdat[`CRCD_CC_IRQ]) begin
        card_functional_irq_flag_ff <= 1'b0;
      end
    end
  end

  // Device control register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      socket_power_lock_ff <= RST_DEV[`CRCD_DC_LOCK];
      low_voltage_capable_force_ff <= RST_DEV[`CRCD_DC_LV_CAP];
      diagnostic_default_one_ff <= RST_DEV[`CRCD_DC_DIAG];
      test_bit3_ff <= RST_DEV[`CRCD_DC_TEST3];
      irq_signaling_mode_ff <= RST_DEV[`CRCD_DC_MODE_HI:`CRCD_DC_MODE_LO];
      test_bit0_ff <= RST_DEV[`CRCD_DC_TEST0];
    end else if (wr_dev) begin
      socket_power_lock_ff <= wdat[`CRCD_DC_LOCK];
      low_voltage_capable_force_ff <= wdat[`CRCD_DC_LV_CAP];
      diagnostic_default_one_ff <= wdat[`CRCD_DC_DIAG];
      // Test bits only stored; no function behind them
      test_bit3_ff <= wdat[`CRCD_DC_TEST3];
      irq_signaling_mode_ff <= wdat[`CRCD_DC_MODE_HI:`CRCD_DC_MODE_LO];
      test_bit0_ff <= wdat[`CRCD_DC_TEST0];
    end
  end

  // Routed outputs, one register stage
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ring_to_mfunc_out <= 1'b0;
      ring_to_wake_terminal_out <= 1'b0;
      compat_video_hiz_out <= 1'b0;
      card_audio_pwm_function_out <= 1'b0;
      speaker_output_terminal_out <= 1'b0;
      speaker_output_oe_out <= 1'b0;
      socket_power_off_out <= 1'b0;
    end else begin
      ring_to_mfunc_out <= ring_output_enable_ff &
                           ring_indicate_output_in;
      ring_to_wake_terminal_out <= ring_output_enable_ff &
                                   ~ring_terminal_select_in &
                                   ring_indicate_output_in;
      compat_video_hiz_out <= compat_video_enable_ff;
      card_audio_pwm_function_out <= audio_to_mux_enable_ff &
                                     card_audio_signal_in;
      // Pin released, not driven low, while disabled
      speaker_output_oe_out <= speaker_route_enable_ff;
      speaker_output_terminal_out <= speaker_route_enable_ff &
                                     card_speaker_signal_in;
      // Lock only matters in D3; power-off passes in other states
      socket_power_off_out <= socket_power_off_req_in &
                              ~(socket_power_lock_ff & in_d3_state_in);
    end
  end

  // Configuration mirrors; kept apart so pin routing stays one small process
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_voltage_capable_out <= RST_DEV[`CRCD_DC_LV_CAP];
      irq_signaling_mode_out <= RST_DEV[`CRCD_DC_MODE_HI:`CRCD_DC_MODE_LO];
    end else begin
      low_voltage_capable_out <= low_voltage_capable_force_ff;
      irq_signaling_mode_out <= irq_signaling_mode_ff;
    end
  end

endmodule // crcd_top
`default_nettype wire

// >>> verification/crcd_checker.sv
// Port-level assertions for the bridge control register block
`timescale 1ns/1ps
`default_nettype none
module crcd_checker #(
  parameter [15:0] RETRY_LIMIT = 16'h8000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic ring_indicate_output_in,
  input wire logic ring_terminal_select_in,
  input wire logic card_audio_signal_in,
  input wire logic card_speaker_signal_in,
  input wire logic socket_power_off_req_in,
  input wire logic ring_to_mfunc_out,
  input wire logic ring_to_wake_terminal_out,
  input wire logic card_audio_pwm_function_out,
  input wire logic speaker_output_terminal_out,
  input wire logic speaker_output_oe_out,
  input wire logic socket_power_off_out
);
  logic [31:0] rd_addr_ff;
  logic rd_take;
  assign rd_take = hsel_in & hready_in & (htrans_in == 2'h2) & ~hwrite_in;
  // Remember the read address so the answer can be judged by register
  always @(posedge clk_in) begin
    if (rd_take) begin
      rd_addr_ff <= haddr_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_read_wait: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  chk_resp_okay: assert property (!hresp_out)
    else $error("response not okay");
  chk_rdata_upper: assert property ($rose(hreadyout_out) |-> hrdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_retry_rsvd: assert property ($rose(hreadyout_out) && rd_addr_ff == 32'h0000_0240 |-> hrdata_out[4] == 1'b0 && hrdata_out[2] == 1'b0 && hrdata_out[0] == 1'b0)
    else $error("retry reserved bit set");
  chk_card_rsvd: assert property ($rose(hreadyout_out) && rd_addr_ff == 32'h0000_0244 |-> hrdata_out[4:3] == 2'h0)
    else $error("card reserved bits set");
  chk_dev_rsvd: assert property ($rose(hreadyout_out) && rd_addr_ff == 32'h0000_0248 |-> hrdata_out[4] == 1'b0)
    else $error("device reserved bit set");
  chk_ring_gate: assert property (ring_to_mfunc_out |-> $past(ring_indicate_output_in))
    else $error("ring routed while idle");
  chk_wake_select: assert property (ring_to_wake_terminal_out |-> ring_to_mfunc_out && !$past(ring_terminal_select_in))
    else $error("ring wake routing wrong");
  chk_audio_gate: assert property (card_audio_pwm_function_out |-> $past(card_audio_signal_in))
    else $error("audio routed while idle");
  chk_card_speaker_signal_follow: assert property (speaker_output_terminal_out == (speaker_output_oe_out & $past(card_speaker_signal_in)))
    else $error("speaker output wrong");
  chk_power_req: assert property (socket_power_off_out |-> $past(socket_power_off_req_in))
    else $error("power off without request");
  cov_read: cover property (rd_take ##2 hreadyout_out);
  cov_wake: cover property (ring_to_wake_terminal_out);
  cov_card_speaker_signal: cover property (speaker_output_terminal_out);
endmodule // crcd_checker
bind crcd_top crcd_checker #(.RETRY_LIMIT(RETRY_LIMIT)) chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .ring_indicate_output_in(ring_indicate_output_in),
  .ring_terminal_select_in(ring_terminal_select_in), .card_audio_signal_in(card_audio_signal_in),
  .card_speaker_signal_in(card_speaker_signal_in), .socket_power_off_req_in(socket_power_off_req_in),
  .ring_to_mfunc_out(ring_to_mfunc_out), .ring_to_wake_terminal_out(ring_to_wake_terminal_out),
  .card_audio_pwm_function_out(card_audio_pwm_function_out),
  .speaker_output_terminal_out(speaker_output_terminal_out), .speaker_output_oe_out(speaker_output_oe_out),
  .socket_power_off_out(socket_power_off_out));
`default_nettype wire

// >>> verification/crcd_master_model.sv
// Far-side master model: takes a retry and comes back after a set delay
`timescale 1ns/1ps
`default_nettype none
module crcd_master_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] start_in,
  input wire logic [15:0] ret_dly_in,
  output logic [2:0] retry_issued_out = 3'h0,
  output logic [2:0] master_returned_out = 3'h0
);
  // Zero delay models a master that never comes back
  logic [15:0] wait_ff [3];
  always @(posedge clk_in) begin
    for (int p = 0; p < 3; p++) begin
      retry_issued_out[p] <= rst_n_in & start_in[p];
      master_returned_out[p] <= rst_n_in & (wait_ff[p] == 16'h0001);
      if (!rst_n_in) begin
        wait_ff[p] <= 16'h0000;
      end else if (start_in[p]) begin
        wait_ff[p] <= ret_dly_in;
      end else if (wait_ff[p] != 16'h0000) begin
        wait_ff[p] <= wait_ff[p] - 16'h0001;
      end
    end
  end
endmodule // crcd_master_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the bridge control register block
`timescale 1ns/1ps
`default_nettype none
`include "crcd_regs.vh"
module tb_top;
  localparam logic [31:0] A_RS = {18'h0, `CRCD_IDX_RETRY, 2'h0};
  localparam logic [31:0] A_CC = {18'h0, `CRCD_IDX_CARD, 2'h0};
  localparam logic [31:0] A_DC = {18'h0, `CRCD_IDX_DEV, 2'h0};
  logic clk_in = 0, rst_n_in = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, mode;
  logic [2:0] start = 0, retry, back;
  logic [15:0] dly = 0;
  logic ring = 0, rsel = 0, aud = 0, spk = 0, irq = 0, d3 = 0, preq = 0;
  logic hready, hresp, r2m, r2w, vid, apwm, spo, spoe, poff, lvc;
  logic [7:0] d, f, en;
  int err_count = 0, samples_checked = 0, cyc = 0;
  always #25 clk_in = ~clk_in;
  crcd_top #(.RETRY_LIMIT(16'h0010)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .retry_issued_in(retry), .master_returned_in(back), .ring_indicate_output_in(ring),
    .ring_terminal_select_in(rsel), .card_audio_signal_in(aud), .card_speaker_signal_in(spk),
    .card_functional_irq_in(irq), .in_d3_state_in(d3), .socket_power_off_req_in(preq),
    .ring_to_mfunc_out(r2m), .ring_to_wake_terminal_out(r2w), .compat_video_hiz_out(vid),
    .card_audio_pwm_function_out(apwm), .speaker_output_terminal_out(spo), .speaker_output_oe_out(spoe),
    .socket_power_off_out(poff), .low_voltage_capable_out(lvc), .irq_signaling_mode_out(mode));
  crcd_master_model far_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start), .ret_dly_in(dly),
    .retry_issued_out(retry), .master_returned_out(back));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer; a read compares the whole word
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd, input logic [7:0] exp);
    @(posedge clk_in);
    htrans <= `CRCD_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_in); while (hready !== 1'b1);
    if (!w) check(hrdata, {24'h0, exp});
  endtask
  task automatic give_verdict();
    $display("TB: checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(91546));
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1;
    @(negedge clk_in);
    check({lvc, mode}, 3'h7);
    bus(0, A_RS, 0, 8'hc0);
    bus(0, A_CC, 0, 8'h00);
    bus(0, A_DC, 0, 8'h66);
    bus(1, 32'h1000_0240, 8'h00, 0);
    bus(0, 32'h0000_024c, 0, 8'h00);
    bus(0, A_RS, 0, 8'hc0);
    bus(1, A_RS, 8'h3f, 0);
    bus(0, A_RS, 0, 8'h00);
    bus(1, A_RS, 8'hff, 0);
    bus(0, A_RS, 0, 8'hc0);
    $display("TB: reset and bus test done");
    for (int p = 0; p < 3; p++) begin
      f = 8'h02 << (2 * p);
      en = (p == 0) ? 8'h80 : 8'h40;
      for (int k = 0; k < 3; k++) begin
        bus(1, A_RS, (k == 2) ? 8'hc0 & ~en : 8'hc0, 0);
        dly <= (k == 1) ? 16'h0005 : 16'h0000;
        start[p] <= 1'b1;
        @(posedge clk_in);
        start <= 3'h0;
        repeat (24) @(posedge clk_in);
        bus(0, A_RS, 0, (k == 0) ? 8'hc0 | f : (k == 1) ? 8'hc0 : 8'hc0 & ~en);
        if (k == 0) begin
          bus(1, A_RS, 8'hc0, 0);
          bus(0, A_RS, 0, 8'hc0 | f);
          bus(1, A_RS, 8'hc0 | f, 0);
          bus(0, A_RS, 0, 8'hc0);
        end
      end
    end
    $display("TB: retry test done");
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'h86 : 8'($urandom) & 8'hdf;
      bus(1, A_CC, d, 0);
      bus(0, A_CC, 0, d & 8'hc6);
      {ring, rsel, aud, spk} <= (i == 0) ? 4'hb : 4'($urandom);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check({r2m, r2w, vid, apwm, spo, spoe}, {d[7] & ring, d[7] & ~rsel & ring, d[6], d[2] & aud, d[1] & spk, d[1]});
    end
    @(posedge clk_in);
    irq <= 1'b1;
    @(posedge clk_in);
    irq <= 1'b0;
    bus(0, A_CC, 0, (d & 8'hc6) | 8'h01);
    bus(1, A_CC, d & 8'hde, 0);
    bus(0, A_CC, 0, (d & 8'hc6) | 8'h01);
    bus(1, A_CC, (d & 8'hdf) | 8'h01, 0);
    bus(0, A_CC, 0, d & 8'hc6);
    $display("TB: card control test done");
    for (int i = 0; i < 8; i++) begin
      d = (8'($urandom) & 8'h60) | {i[2], 4'h0, i[1:0], 1'b0};
      bus(1, A_DC, d | 8'h10, 0);
      bus(0, A_DC, 0, d);
      d3 <= i[0];
      preq <= i[1];
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check({lvc, mode, poff}, {d[6], d[2:1], i[1] & ~(d[7] & i[0])});
    end
    $display("TB: device control test done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
